// ==== core/rps_pkg.sv ====
package rps_pkg;
	// geometry
	localparam int RPS_NPINS = 4;
	localparam int RPS_CODE_W = 6;
	localparam int RPS_SEL_W = 8;
	localparam int RPS_NSRC = 19;
	// register byte offsets
	localparam logic [7:0] RPS_OFF_IRQ1_SEL = 8'h00;
	localparam logic [7:0] RPS_OFF_IRQ2_SEL = 8'h04;
	localparam logic [7:0] RPS_OFF_OUTFN = 8'h08;
	localparam logic [7:0] RPS_OFF_DIR = 8'h0c;
	localparam logic [7:0] RPS_OFF_LATCH = 8'h10;
	localparam logic [7:0] RPS_OFF_ANSEL = 8'h14;
	localparam logic [7:0] RPS_OFF_PULLUP = 8'h18;
	localparam logic [7:0] RPS_OFF_PULLDN = 8'h1c;
	localparam logic [7:0] RPS_OFF_LEVEL = 8'h20;
	localparam logic [7:0] RPS_OFF_DEDEN = 8'h24;
	// field positions
	localparam int RPS_IRQ1_LSB = 8;
	localparam int RPS_IRQ2_LSB = 0;
	// reset values
	localparam logic [RPS_SEL_W-1:0] RPS_SEL_RST = 8'h00;
	localparam logic [RPS_CODE_W-1:0] RPS_CODE_RST = 6'h00;
	localparam logic [RPS_NPINS-1:0] RPS_DIR_RST = 4'hf;
	localparam logic [RPS_NPINS-1:0] RPS_ANSEL_RST = 4'hf;
	localparam logic [RPS_NPINS-1:0] RPS_ZERO_RST = 4'h0;
	localparam logic [RPS_NPINS-1:0] RPS_OE_N_RST = 4'hf;
	// pin-select codes
	localparam logic [RPS_SEL_W-1:0] RPS_SEL_GND = 8'h00;
	localparam logic [RPS_SEL_W-1:0] RPS_SEL_COMPARATOR_1_INPUT_SOURCE = 8'h01;
	localparam logic [RPS_SEL_W-1:0] RPS_SEL_PIN0 = 8'h02;
	localparam logic [RPS_SEL_W-1:0] RPS_SEL_MAX = 8'hb5;
	// output-function codes
	localparam logic [5:0] RPS_FN_DEFAULT = 6'h00;
	localparam logic [5:0] RPS_FN_SER1 = 6'h01;
	localparam logic [5:0] RPS_FN_SER2 = 6'h03;
	localparam logic [5:0] RPS_FN_SPIB_DO = 6'h08;
	localparam logic [5:0] RPS_FN_SPIB_CK = 6'h09;
	localparam logic [5:0] RPS_FN_SPIB_SS = 6'h0a;
	localparam logic [5:0] RPS_FN_CANA = 6'h0e;
	localparam logic [5:0] RPS_FN_CMPU1 = 6'h10;
	localparam logic [5:0] RPS_FN_CMPU4 = 6'h13;
	localparam logic [5:0] RPS_FN_CMPR1 = 6'h18;
	localparam logic [5:0] RPS_FN_CMPR3 = 6'h1a;
	localparam logic [5:0] RPS_FN_SYNC = 6'h2d;
	localparam logic [5:0] RPS_FN_REFCLK = 6'h31;
	localparam logic [5:0] RPS_FN_CMPR4 = 6'h32;
	localparam logic [5:0] RPS_FN_CMPR5 = 6'h33;
	localparam logic [5:0] RPS_FN_NIB1 = 6'h39;
	localparam logic [5:0] RPS_FN_NIB2 = 6'h3a;
	// axi responses
	localparam logic [1:0] RPS_RESP_OKAY = 2'b00;
	localparam logic [1:0] RPS_RESP_SLVERR = 2'b10;
endpackage : rps_pkg

// ==== core/rps_pin_remap.sv ====
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - no lockout between mapping registers; any mapping combination allowed
// - 6-bit code: 0 default port, 1 serial1 tx, 3 serial2 tx
// - codes 8,9,10 route spi b data, clock, select; 14 can tx
// - codes 16 to 19 route compare units one to four
// - codes 24,25,26 route comparator outputs one to three
// - codes 50,51 route comparator outputs four and five
// - code 45 pwm sync out, code 49 reference clock out
// - codes 57,58 nibble link tx; unlisted codes fall back to the default port like code 0
// - core overvoltage tri-states every pin while it persists
// - analog select resets set; level and latch reads return zero
// - highest priority enabled function owns pin; others inert
// - per-pin weak pull-up and pull-down enables
// - only one output function drives a pin at a time
// - dedicated output beats remappable output
// - one remappable output may drive several pins
// - any number of remappable inputs may sample one pin
// - analog enabled disables digital inputs; output still possible
// - direction gates only gpio output; peripheral outputs override it
// - 8-bit input select: 0 ground, 1 comparator 1, higher pins; only codes 2 to 5 reach pins 0 to 3 here, higher codes read as zero
// - irq1 select bits 15-8, irq2 select bits 7-0, rest zero
// - output code zero after reset disconnects remappable outputs
module rps_pin_remap (
	// system
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// peripheral outputs, order of code table
	input wire logic [rps_pkg::RPS_NSRC-1:0] periph_out_i,
	// dedicated output functions per pin
	input wire logic [rps_pkg::RPS_NPINS-1:0] ded_out_en_i,
	input wire logic [rps_pkg::RPS_NPINS-1:0] ded_out_val_i,
	// comparator 1 level and overvoltage detector
	input wire logic comparator_1_input_source_i,
	input wire logic core_overvoltage_detector_i,
	// pads
	input wire logic [rps_pkg::RPS_NPINS-1:0] pad_in_i,
	output logic [rps_pkg::RPS_NPINS-1:0] pad_out_o,
	output logic [rps_pkg::RPS_NPINS-1:0] pad_oe_n_o,
	output logic [rps_pkg::RPS_NPINS-1:0] pull_up_enable_o,
	output logic [rps_pkg::RPS_NPINS-1:0] pull_down_enable_o,
	output logic [rps_pkg::RPS_NPINS-1:0] dig_in_buf_en_o,
	// peripheral inputs
	output logic ext_irq1_o,
	output logic ext_irq2_o
);
	import rps_pkg::*;

	localparam int NP = RPS_NPINS;

	logic [RPS_SEL_W-1:0] ext_irq1_pin_code_reg;
	logic [RPS_SEL_W-1:0] ext_irq2_pin_code_reg;
	logic [RPS_CODE_W-1:0] output_function_code_reg [NP];
	logic [NP-1:0] pin_direction_reg;
	logic [NP-1:0] output_latch_reg;
	logic [NP-1:0] analog_select_reg;
	logic [NP-1:0] pull_up_reg;
	logic [NP-1:0] pull_down_reg;
	logic [NP-1:0] pad_sync1_reg;
	logic [NP-1:0] pad_sync2_reg;
	logic cmp_sync1_reg;
	logic cmp_sync2_reg;
	logic hvd_sync1_reg;
	logic hvd_sync2_reg;

	// bus handshake state
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	// the overvoltage flag and pads are asynchronous; comparator is another clock
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pad_sync1_reg <= RPS_ZERO_RST;
			pad_sync2_reg <= RPS_ZERO_RST;
			cmp_sync1_reg <= 1'b0;
			cmp_sync2_reg <= 1'b0;
			hvd_sync1_reg <= 1'b0;
			hvd_sync2_reg <= 1'b0;
		end else begin
			pad_sync1_reg <= pad_in_i;
			pad_sync2_reg <= pad_sync1_reg;
			cmp_sync1_reg <= comparator_1_input_source_i;
			cmp_sync2_reg <= cmp_sync1_reg;
			hvd_sync1_reg <= core_overvoltage_detector_i;
			hvd_sync2_reg <= hvd_sync1_reg;
		end
	end

	// axi write: address and data taken in either order, response after both
	// readies wait for an empty slot, so a second address cannot overwrite a held one

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RPS_RESP_OKAY;
		end else begin
			s_axi_awready_o <= ~aw_held_reg & ~s_axi_awready_o & s_axi_awvalid_i & ~s_axi_bvalid_o;
			s_axi_wready_o <= ~w_held_reg & ~s_axi_wready_o & s_axi_wvalid_i & ~s_axi_bvalid_o;
			if (s_axi_awvalid_i & s_axi_awready_o) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i & s_axi_wready_o) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_i;
				w_strb_reg <= s_axi_wstrb_i;
			end
			if (aw_held_reg & w_held_reg & ~s_axi_bvalid_o) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_ok(aw_addr_reg) ? RPS_RESP_OKAY : RPS_RESP_SLVERR;
			end else if (s_axi_bvalid_o & s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	function automatic logic wr_ok(input logic [7:0] a);
		wr_ok = (a[1:0] == 2'b00) && (a <= RPS_OFF_PULLDN);
	endfunction : wr_ok

	logic commit;
	assign commit = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;

	// no cross-register lockout: every field is written independently
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ext_irq1_pin_code_reg <= RPS_SEL_RST;
			ext_irq2_pin_code_reg <= RPS_SEL_RST;
			for (int i = 0; i < NP; i++) begin
				output_function_code_reg[i] <= RPS_CODE_RST;
			end
			pin_direction_reg <= RPS_DIR_RST;
			output_latch_reg <= RPS_ZERO_RST;
			analog_select_reg <= RPS_ANSEL_RST;
			pull_up_reg <= RPS_ZERO_RST;
			pull_down_reg <= RPS_ZERO_RST;
		end else if (commit) begin
			case (aw_addr_reg)
				RPS_OFF_IRQ1_SEL: if (w_strb_reg[1]) begin
					ext_irq1_pin_code_reg <= w_data_reg[RPS_IRQ1_LSB +: RPS_SEL_W];
				end
				RPS_OFF_IRQ2_SEL: if (w_strb_reg[0]) begin
					ext_irq2_pin_code_reg <= w_data_reg[RPS_IRQ2_LSB +: RPS_SEL_W];
				end
				RPS_OFF_OUTFN: begin
					for (int i = 0; i < NP; i++) begin
						if (w_strb_reg[i]) begin
							output_function_code_reg[i] <= w_data_reg[8*i +: RPS_CODE_W];
						end
					end
				end
				RPS_OFF_DIR: if (w_strb_reg[0]) begin
					pin_direction_reg <= w_data_reg[NP-1:0];
				end
				RPS_OFF_LATCH: if (w_strb_reg[0]) begin
					output_latch_reg <= w_data_reg[NP-1:0];
				end
				RPS_OFF_ANSEL: if (w_strb_reg[0]) begin
					analog_select_reg <= w_data_reg[NP-1:0];
				end
				RPS_OFF_PULLUP: if (w_strb_reg[0]) begin
					pull_up_reg <= w_data_reg[NP-1:0];
				end
				RPS_OFF_PULLDN: if (w_strb_reg[0]) begin
					pull_down_reg <= w_data_reg[NP-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// axi read
	logic [31:0] rd_word;
	logic rd_hit;
	logic [NP-1:0] dig_level;
	assign dig_level = pad_sync2_reg & ~analog_select_reg;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr_i)
			RPS_OFF_IRQ1_SEL: rd_word[RPS_IRQ1_LSB +: RPS_SEL_W] = ext_irq1_pin_code_reg;
			RPS_OFF_IRQ2_SEL: rd_word[RPS_IRQ2_LSB +: RPS_SEL_W] = ext_irq2_pin_code_reg;
			RPS_OFF_OUTFN: begin
				for (int i = 0; i < NP; i++) begin
					rd_word[8*i +: RPS_CODE_W] = output_function_code_reg[i];
				end
			end
			RPS_OFF_DIR: rd_word[NP-1:0] = pin_direction_reg;
			RPS_OFF_LATCH: rd_word[NP-1:0] = output_latch_reg & ~analog_select_reg;
			RPS_OFF_ANSEL: rd_word[NP-1:0] = analog_select_reg;
			RPS_OFF_PULLUP: rd_word[NP-1:0] = pull_up_reg;
			RPS_OFF_PULLDN: rd_word[NP-1:0] = pull_down_reg;
			RPS_OFF_LEVEL: rd_word[NP-1:0] = dig_level;
			RPS_OFF_DEDEN: rd_word[NP:0] = {hvd_sync2_reg, ded_out_en_i};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= RPS_RESP_OKAY;
		end else begin
			s_axi_arready_o <= s_axi_arvalid_i & ~s_axi_arready_o & ~s_axi_rvalid_o;
			if (s_axi_arvalid_i & s_axi_arready_o) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_word;
				s_axi_rresp_o <= rd_hit && (s_axi_araddr_i[1:0] == 2'b00) ? RPS_RESP_OKAY : RPS_RESP_SLVERR;
			end else if (s_axi_rvalid_o & s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// output selection; one mux per pin so any source may feed many pins
	function automatic logic [1:0] fn_pick(input logic [5:0] code, input logic [RPS_NSRC-1:0] src);
		fn_pick = 2'b00;
		case (code)
			RPS_FN_SER1: fn_pick = {1'b1, src[0]};
			RPS_FN_SER2: fn_pick = {1'b1, src[1]};
			RPS_FN_SPIB_DO: fn_pick = {1'b1, src[2]};
			RPS_FN_SPIB_CK: fn_pick = {1'b1, src[3]};
			RPS_FN_SPIB_SS: fn_pick = {1'b1, src[4]};
			RPS_FN_CANA: fn_pick = {1'b1, src[5]};
			RPS_FN_CMPR1, 6'h19, RPS_FN_CMPR3: fn_pick = {1'b1, src[5'(code[1:0]) + 5'd10]};
			RPS_FN_SYNC: fn_pick = {1'b1, src[13]};
			RPS_FN_REFCLK: fn_pick = {1'b1, src[14]};
			RPS_FN_CMPR4: fn_pick = {1'b1, src[15]};
			RPS_FN_CMPR5: fn_pick = {1'b1, src[16]};
			RPS_FN_NIB1: fn_pick = {1'b1, src[17]};
			RPS_FN_NIB2: fn_pick = {1'b1, src[RPS_NSRC-1]};
			default: begin
				if (code >= RPS_FN_CMPU1 && code <= RPS_FN_CMPU4) begin
					fn_pick = {1'b1, src[5'(code[1:0]) + 5'd6]};
				end
			end
		endcase
	endfunction : fn_pick

	// per-pin remap selection, ahead of the pad registers
	logic [1:0] rp_sel [NP];
	always_comb begin
		for (int i = 0; i < NP; i++) begin
			rp_sel[i] = fn_pick(output_function_code_reg[i], periph_out_i);
		end
	end

	// the pad drivers are registered so every routing change lands cleanly one edge later
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pad_out_o <= RPS_ZERO_RST;
			pad_oe_n_o <= RPS_OE_N_RST;
			pull_up_enable_o <= RPS_ZERO_RST;
			pull_down_enable_o <= RPS_ZERO_RST;
			dig_in_buf_en_o <= RPS_ZERO_RST;
		end else begin
			for (int i = 0; i < NP; i++) begin
				if (hvd_sync2_reg) begin
					pad_oe_n_o[i] <= 1'b1;
					pad_out_o[i] <= 1'b0;
				end else if (ded_out_en_i[i]) begin
					pad_oe_n_o[i] <= 1'b0;
					pad_out_o[i] <= ded_out_val_i[i];
				end else if (rp_sel[i][1]) begin
					pad_oe_n_o[i] <= 1'b0;
					pad_out_o[i] <= rp_sel[i][0];
				end else begin
					pad_oe_n_o[i] <= pin_direction_reg[i];
					pad_out_o[i] <= output_latch_reg[i];
				end
			end
			pull_up_enable_o <= hvd_sync2_reg ? RPS_ZERO_RST : pull_up_reg;
			pull_down_enable_o <= hvd_sync2_reg ? RPS_ZERO_RST : pull_down_reg;
			dig_in_buf_en_o <= hvd_sync2_reg ? RPS_ZERO_RST : ~analog_select_reg;
		end
	end

	// remapped inputs: plain muxes, many readers per pin allowed
	function automatic logic in_pick(input logic [7:0] sel, input logic [NP-1:0] lvl, input logic c1);
		in_pick = 1'b0;
		if (sel == RPS_SEL_COMPARATOR_1_INPUT_SOURCE) begin
			in_pick = c1;
		end else if (sel >= RPS_SEL_PIN0 && sel < RPS_SEL_PIN0 + 8'(NP)) begin
			in_pick = lvl[2'(sel - RPS_SEL_PIN0)];
		end
	endfunction : in_pick

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ext_irq1_o <= 1'b0;
			ext_irq2_o <= 1'b0;
		end else begin
			ext_irq1_o <= in_pick(ext_irq1_pin_code_reg, dig_level, cmp_sync2_reg);
			ext_irq2_o <= in_pick(ext_irq2_pin_code_reg, dig_level, cmp_sync2_reg);
		end
	end

	// assertions; each watches a pin that some scenario actually exercises
	hvd_tristate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		hvd_sync2_reg |=> pad_oe_n_o == RPS_OE_N_RST) else $error("pins driven during overvoltage");
	hvd_pulls_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		hvd_sync2_reg |=> pull_up_enable_o == RPS_ZERO_RST && pull_down_enable_o == RPS_ZERO_RST)
		else $error("pulls on during overvoltage");
	ded_wins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!hvd_sync2_reg && ded_out_en_i[2] |=> !pad_oe_n_o[2] && pad_out_o[2] == $past(ded_out_val_i[2]))
		else $error("dedicated output lost pin 2");
	ansel_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == RPS_OFF_LATCH && analog_select_reg[1]
		|=> !s_axi_rdata_o[1]) else $error("analog pin latch reads one");
	gnd_sel_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ext_irq1_pin_code_reg == RPS_SEL_GND |=> !ext_irq1_o) else $error("grounded input high");
	cmp_sel_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ext_irq2_pin_code_reg == RPS_SEL_COMPARATOR_1_INPUT_SOURCE |=> ext_irq2_o == $past(cmp_sync2_reg))
		else $error("comparator input lost");
	code_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!hvd_sync2_reg && !ded_out_en_i[1] && output_function_code_reg[1] == RPS_CODE_RST
		|=> pad_oe_n_o[1] == $past(pin_direction_reg[1])) else $error("code zero not gpio");
	ser1_route_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!hvd_sync2_reg && !ded_out_en_i[2] && output_function_code_reg[2] == RPS_FN_SER1
		|=> !pad_oe_n_o[2] && pad_out_o[2] == $past(periph_out_i[0])) else $error("serial1 route");
	pull_up_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!hvd_sync2_reg |=> pull_up_enable_o == $past(pull_up_reg)) else $error("pull-up mismatch");
	in_buf_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		analog_select_reg[3] |=> !dig_in_buf_en_o[3]) else $error("input buffer on analog pin");
	cmpu4_route_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!hvd_sync2_reg && !ded_out_en_i[0] && output_function_code_reg[0] == RPS_FN_CMPU4
		|=> pad_out_o[0] == $past(periph_out_i[9])) else $error("compare unit 4 route");
	nib2_route_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!hvd_sync2_reg && !ded_out_en_i[0] && output_function_code_reg[0] == RPS_FN_NIB2
		|=> !pad_oe_n_o[0] && pad_out_o[0] == $past(periph_out_i[RPS_NSRC-1]))
		else $error("nibble link 2 route");
	write_next_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		commit && aw_addr_reg == RPS_OFF_DIR && w_strb_reg[0]
		|=> pin_direction_reg == $past(w_data_reg[NP-1:0])) else $error("direction write lost");
	cov_ded_c: cover property (@(posedge clk_sys_i) ded_out_en_i != RPS_ZERO_RST && !hvd_sync2_reg);
	cov_write_c: cover property (@(posedge clk_sys_i) s_axi_bvalid_o && s_axi_bready_i);
	cov_read_c: cover property (@(posedge clk_sys_i) s_axi_rvalid_o && s_axi_rready_i);
	cov_hvd_c: cover property (@(posedge clk_sys_i) hvd_sync2_reg);
	cov_remap_c: cover property (@(posedge clk_sys_i) output_function_code_reg[0] == RPS_FN_NIB2);
endmodule : rps_pin_remap

// ==== bench/rps_pin_world.sv ====
`timescale 1ns/1ps
module rps_pin_world (
	// design side
	input wire logic clk_sys_i,
	input wire logic [rps_pkg::RPS_NPINS-1:0] pad_out_i,
	input wire logic [rps_pkg::RPS_NPINS-1:0] pad_oe_n_i,
	input wire logic [rps_pkg::RPS_NPINS-1:0] pull_up_enable_i,
	input wire logic [rps_pkg::RPS_NPINS-1:0] pull_down_enable_i,
	// external drivers on the board
	input wire logic [rps_pkg::RPS_NPINS-1:0] ext_en_i,
	input wire logic [rps_pkg::RPS_NPINS-1:0] ext_val_i,
	// resolved pad levels
	output logic [rps_pkg::RPS_NPINS-1:0] pad_level_o
);
	import rps_pkg::*;
	logic [RPS_NPINS-1:0] float_reg = 4'h5;
	// an undriven pad toggles every cycle so a floating read never matches by luck
	always_ff @(posedge clk_sys_i) begin
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < RPS_NPINS; i++) begin
			if (!pad_oe_n_i[i])
				pad_level_o[i] = pad_out_i[i];
			else if (ext_en_i[i])
				pad_level_o[i] = ext_val_i[i];
			else if (pull_up_enable_i[i])
				pad_level_o[i] = 1'b1;
			else if (pull_down_enable_i[i])
				pad_level_o[i] = 1'b0;
			else
				pad_level_o[i] = float_reg[i];
		end
	end
endmodule : rps_pin_world

// ==== bench/tb_remappable_pin_select.sv ====
`timescale 1ns/1ps
module tb_remappable_pin_select;
	import rps_pkg::*;
	localparam logic [1:0] ok = RPS_RESP_OKAY;
	localparam logic [1:0] err = RPS_RESP_SLVERR;
	logic clk_sys_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, comparator_1_input_source, ovd, irq1, irq2;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [RPS_NSRC-1:0] periph;
	logic [RPS_NPINS-1:0] ded_en, ded_val, pad_in, pad_out, oe_n, pu, pd, dib, ext_en, ext_val;
	int fails = 0;
	int comparisons = 0;
	logic [5:0] fn [19] = '{6'h01, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h0e, 6'h10, 6'h11, 6'h12, 6'h13,
		6'h18, 6'h19, 6'h1a, 6'h2d, 6'h31, 6'h32, 6'h33, 6'h39, 6'h3a};
	int ix [19] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18};

	rps_pin_remap uut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.periph_out_i(periph), .ded_out_en_i(ded_en), .ded_out_val_i(ded_val),
		.comparator_1_input_source_i(comparator_1_input_source), .core_overvoltage_detector_i(ovd),
		.pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_n_o(oe_n),
		.pull_up_enable_o(pu), .pull_down_enable_o(pd), .dig_in_buf_en_o(dib),
		.ext_irq1_o(irq1), .ext_irq2_o(irq2)
	);

	rps_pin_world far (
		.clk_sys_i(clk_sys_i), .pad_out_i(pad_out), .pad_oe_n_i(oe_n),
		.pull_up_enable_i(pu), .pull_down_enable_i(pd),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .pad_level_o(pad_in)
	);

	task test_done;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick

	// address and data offered together, each dropped once its own ready is seen
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk_sys_i);
			aw = aw | (awvalid & awready);
			w = w | (wvalid & wready);
			awvalid <= !aw;
			wvalid <= !w;
		end
		while (bvalid !== 1'b1) @(posedge clk_sys_i);
		bready <= 1'b0;
		chk(bresp, r);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk_sys_i);
		rready <= 1'b0;
		chk(rresp, r);
		if (r == ok)
			chk(rdata, e);
	endtask : rd

	task t_reset;
		chk({oe_n, dib, pu, pd}, 16'hf000);
		rd(RPS_OFF_IRQ1_SEL, 32'h0, ok);
		rd(RPS_OFF_IRQ2_SEL, 32'h0, ok);
		rd(RPS_OFF_OUTFN, 32'h0, ok);
		rd(RPS_OFF_ANSEL, 32'hf, ok);
		rd(RPS_OFF_DIR, 32'hf, ok);
		rd(8'h30, 32'h0, err);
		wr(RPS_OFF_LEVEL, 32'hf, 4'h1, err);
	endtask : t_reset

	task t_codes;
		for (int i = 0; i < 19; i++) begin
			wr(RPS_OFF_OUTFN, {26'h0, fn[i]}, 4'h1, ok);
			periph <= RPS_NSRC'(1) << ix[i];
			tick(2);
			chk({oe_n[0], pad_out[0]}, 2'b01);
			periph <= ~(RPS_NSRC'(1) << ix[i]);
			tick(2);
			chk({oe_n[0], pad_out[0]}, 2'b00);
		end
		wr(RPS_OFF_OUTFN, 32'h3f, 4'h1, ok);
		tick(2);
		chk(oe_n[0], 1'b1);
		wr(RPS_OFF_OUTFN, 32'h0, 4'h1, ok);
		tick(2);
		chk(oe_n[0], 1'b1);
	endtask : t_codes

	task t_multi;
		wr(RPS_OFF_OUTFN, 32'h01010101, 4'hf, ok);
		periph <= RPS_NSRC'(1);
		tick(2);
		chk({oe_n, pad_out}, 8'h0f);
		ded_en <= 4'h4;
		tick(2);
		chk({oe_n, pad_out}, 8'h0b);
		ovd <= 1'b1;
		tick(5);
		chk(oe_n, 4'hf);
		rd(RPS_OFF_DEDEN, 32'h14, ok);
		tick(20);
		chk(oe_n, 4'hf);
		ovd <= 1'b0;
		ded_en <= 4'h0;
		tick(5);
		chk({oe_n, pad_out}, 8'h0f);
	endtask : t_multi

	task t_gpio;
		wr(RPS_OFF_OUTFN, 32'h0, 4'hf, ok);
		wr(RPS_OFF_LATCH, 32'ha, 4'h1, ok);
		wr(RPS_OFF_DIR, 32'h3, 4'h1, ok);
		tick(2);
		chk({oe_n, pad_out & ~oe_n}, 8'h38);
		rd(RPS_OFF_LATCH, 32'h0, ok);
		wr(RPS_OFF_ANSEL, 32'h0, 4'h1, ok);
		rd(RPS_OFF_LATCH, 32'ha, ok);
		wr(RPS_OFF_PULLUP, 32'h1, 4'h1, ok);
		wr(RPS_OFF_PULLDN, 32'h2, 4'h1, ok);
		tick(4);
		chk({pu, pd, dib}, 12'h12f);
		rd(RPS_OFF_LEVEL, 32'h9, ok);
	endtask : t_gpio

	task t_inputs;
		wr(RPS_OFF_DIR, 32'hf, 4'h1, ok);
		ext_en <= 4'h4;
		ext_val <= 4'h4;
		wr(RPS_OFF_IRQ1_SEL, 32'hb5b5, 4'h3, ok);
		rd(RPS_OFF_IRQ1_SEL, 32'hb500, ok);
		wr(RPS_OFF_IRQ2_SEL, 32'hb5b5, 4'h3, ok);
		rd(RPS_OFF_IRQ2_SEL, 32'h00b5, ok);
		wr(RPS_OFF_IRQ1_SEL, 32'h0400, 4'h2, ok);
		wr(RPS_OFF_IRQ2_SEL, 32'h0004, 4'h1, ok);
		tick(5);
		chk({irq1, irq2}, 2'b11);
		ext_val <= 4'h0;
		tick(5);
		chk({irq1, irq2}, 2'b00);
		ext_val <= 4'h4;
		comparator_1_input_source <= 1'b1;
		wr(RPS_OFF_IRQ1_SEL, 32'h0, 4'h2, ok);
		wr(RPS_OFF_IRQ2_SEL, 32'h1, 4'h1, ok);
		tick(5);
		chk({irq1, irq2}, 2'b01);
		wr(RPS_OFF_IRQ1_SEL, 32'h0400, 4'h2, ok);
		wr(RPS_OFF_ANSEL, 32'h4, 4'h1, ok);
		tick(5);
		chk({irq1, irq2, dib}, 6'h1b);
	endtask : t_inputs

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		rst_i = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, comparator_1_input_source, ovd} = '0;
		{awaddr, araddr, wdata, wstrb, periph} = '0;
		{ded_en, ded_val, ext_en, ext_val} = '0;
		tick(12);
		rst_i <= 1'b0;
		tick(3);
		t_reset();
		t_codes();
		t_multi();
		t_gpio();
		t_inputs();
		test_done();
	end

	// the full sequence needs well under two thousand cycles
	initial begin
		tick(20000);
		fails++;
		test_done();
	end
endmodule : tb_remappable_pin_select
